// *** common/ict_pkg.sv ***
// Shared classes, cycle costs and carriers for the instruction cycle timer
package ict_pkg;

  localparam int COST_W = 8;
  localparam int NREG_W = 5;

  // Execution cost of each instruction class, in core clock cycles
  localparam logic [COST_W-1:0] CYC_ONE         = 8'h01;
  localparam logic [COST_W-1:0] CYC_LDST        = 8'h02;
  localparam logic [COST_W-1:0] CYC_MULTI_BASE  = 8'h01;
  localparam logic [COST_W-1:0] CYC_POPRET_BASE = 8'h04;
  localparam logic [COST_W-1:0] CYC_BR_TAKEN    = 8'h03;
  localparam logic [COST_W-1:0] CYC_BR_NOT      = 8'h01;
  localparam logic [COST_W-1:0] CYC_BRANCH      = 8'h03;
  localparam logic [COST_W-1:0] CYC_BR_LINK     = 8'h04;
  localparam logic [COST_W-1:0] CYC_PC_WRITE    = 8'h03;
  localparam logic [COST_W-1:0] CYC_BARRIER     = 8'h04;
  localparam logic [COST_W-1:0] CYC_SPEC_READ   = 8'h04;
  localparam logic [COST_W-1:0] CYC_HINT_WAIT   = 8'h02;

  typedef enum logic [4:0] {
    CLS_ALU         = 5'h00,  // Logic, move, add/sub, compare, address form
    CLS_SHIFT       = 5'h01,
    CLS_MUL         = 5'h02,  // multiply_low_word
    CLS_EXTEND      = 5'h03,
    CLS_REVERSE     = 5'h04,  // Including halfword_byte_swap and signed form
    CLS_LDST        = 5'h05,
    CLS_MULTI       = 5'h06,  // load_multiple, store_multiple, push, pop
    CLS_POP_RET     = 5'h07,
    CLS_BCOND       = 5'h08,
    CLS_BRANCH      = 5'h09,  // Plain, register_branch and its link form
    CLS_BRANCH_LINK = 5'h0a,  // branch_with_link
    CLS_PC_WRITE    = 5'h0b,
    CLS_BARRIER     = 5'h0c,
    CLS_SPEC_READ   = 5'h0d,  // special_register_read
    CLS_HINT_WAIT   = 5'h0e,  // wait_for_event_hint, wait_for_interrupt_hint
    CLS_HINT_ONE    = 5'h0f,  // Yield, no-op, send_event_hint, mask set/clear
    CLS_SUP_CALL    = 5'h10   // supervisor_call
  } ict_class_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_WAIT = 3'h4
  } ict_state_e;

  typedef struct packed {
    ict_class_e          cls;
    logic [NREG_W-1:0]   n_regs;     // Transferred elements, PC included
    logic                cond_pass;  // Branch condition outcome
  } ict_issue_s;

  typedef struct packed {
    ict_class_e          cls;
    logic [COST_W-1:0]   cost;
  } ict_report_s;

endpackage

// *** core/ict_down_counter.sv ***
// Loadable down counter that flags its final count
`timescale 1ns/1ps
module ict_down_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic [W-1:0]      count,
  output logic              last
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign nxt_cnt = load ? load_val :
                   (cnt_ff != '0) ? W'(cnt_ff - 1'b1) : cnt_ff;
  assign count   = cnt_ff;
  assign last    = (cnt_ff == W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// *** core/ict_cycle_timer.sv ***
// Instruction cycle timer: holds each issued instruction for its cost
`timescale 1ns/1ps
// What this block does
// (RULE1) Every shift, by immediate or register amount, takes one cycle.
// (RULE2) Logic, moves, compares, negate, add/sub, address forms: one cycle.
// (RULE3) The low-word 32x32 multiply completes in one cycle.
// (RULE4) Each single load or store, any width or addressing: two cycles.
// (RULE5) Multiple transfers, push, plain pop: one plus one per register.
// (RULE6) Returning pop: four plus one per element, PC counted, if no fault.
// (RULE7) Conditional branch takes three cycles if taken, one if not.
// (RULE8) Plain and register branches: three cycles; branch with link: four.
// (RULE9) Sign or zero extension of byte or halfword takes one cycle.
// (RULE10) Each byte reverse form takes one cycle.
// (RULE11) Wait hints charge two cycles, idle time for the wake excluded.
// (RULE12) Supervisor call cost comes from configuration, not a fixed figure.
// (RULE13) PC-writing move/add: three; barriers and special reads: four.
// (RULE14) Yield, no-op, send event, mask set and clear: one cycle.
module ict_cycle_timer
  import ict_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               issue_valid,
  output logic                    issue_ready,
  input  wire ict_issue_s         issue,
  input  wire logic [COST_W-1:0]  call_cycles,
  input  wire logic               wake,
  input  wire logic               mem_fault,
  output logic                    retire,
  output logic                    abort,
  output logic                    waiting,
  output ict_report_s             report
);

  ict_state_e        st_ff;
  ict_state_e        nxt_st;
  ict_class_e        cur_cls_ff;
  // Operand figures kept only so the length checks have their own reference
  logic [NREG_W-1:0] nreg_ff;
  logic [COST_W-1:0] call_ff;
  ict_report_s       report_ff;
  ict_report_s       nxt_report;

  function automatic logic [COST_W-1:0] cost_of(
    input ict_issue_s        iss,
    input logic [COST_W-1:0] call_c
  );
    logic [COST_W-1:0] c;
    c = CYC_ONE;
    case (iss.cls)
      CLS_LDST:        c = CYC_LDST;                               // see RULE4
      CLS_MULTI:       c = COST_W'(CYC_MULTI_BASE + iss.n_regs);   // see RULE5
      CLS_POP_RET:     c = COST_W'(CYC_POPRET_BASE + iss.n_regs);  // see RULE6
      CLS_BCOND: c = iss.cond_pass ? CYC_BR_TAKEN : CYC_BR_NOT; // see RULE7
      CLS_BRANCH:      c = CYC_BRANCH;                             // see RULE8
      CLS_BRANCH_LINK: c = CYC_BR_LINK;                            // see RULE8
      CLS_PC_WRITE:    c = CYC_PC_WRITE;                           // see RULE13
      CLS_BARRIER:     c = CYC_BARRIER;                            // see RULE13
      CLS_SPEC_READ:   c = CYC_SPEC_READ;                          // see RULE13
      CLS_HINT_WAIT:   c = CYC_HINT_WAIT;                          // see RULE11
      CLS_HINT_ONE:    c = CYC_ONE; // see RULE14
      // A zero setting would wrap the count to 256 cycles, so it costs one cycle
      CLS_SUP_CALL:    c = (call_c == '0) ? CYC_ONE : call_c; // see RULE12
      default:         c = CYC_ONE; // see RULE1 RULE2 RULE3 RULE9 RULE10
    endcase
    return c;
  endfunction

  logic [COST_W-1:0] issue_cost;
  logic              accept;
  logic              single;
  logic              cnt_last;
  logic              in_idle;
  logic              in_exec;
  logic              in_wait;
  logic              mem_class;
  logic              exec_fault;
  logic              exec_end;
  logic              exec_retire;
  logic              wait_retire;

  assign in_idle     = (st_ff == ST_IDLE);
  assign in_exec     = (st_ff == ST_EXEC);
  assign in_wait     = (st_ff == ST_WAIT);
  assign issue_ready = in_idle;
  assign accept      = issue_valid && issue_ready;
  assign issue_cost  = cost_of(issue, call_cycles);
  assign single      = (issue_cost == CYC_ONE);
  // Faults only matter while the data phase of a transfer is running
  assign mem_class   = (cur_cls_ff == CLS_LDST) || (cur_cls_ff == CLS_MULTI)
                    || (cur_cls_ff == CLS_POP_RET);
  assign exec_fault  = in_exec && mem_class && mem_fault; // see RULE6
  assign exec_end    = in_exec && cnt_last && !exec_fault;
  // Wake already present at the end of the charge ends the hint at once
  assign exec_retire = exec_end && (cur_cls_ff != CLS_HINT_WAIT || wake);
  assign wait_retire = in_wait && wake; // see RULE11
  assign retire      = (accept && single) || exec_retire || wait_retire;
  assign abort       = exec_fault;
  assign waiting     = in_wait;
  assign report      = report_ff;

  ict_down_counter #(
    .W (COST_W)
  ) u_count (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (accept && !single),
    .load_val (COST_W'(issue_cost - 1'b1)),
    .count    (),
    .last     (cnt_last)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (accept && !single) begin
          nxt_st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (exec_fault || exec_retire) begin
          nxt_st = ST_IDLE;
        end else if (exec_end) begin
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wake) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  assign nxt_report = accept ? '{cls: issue.cls, cost: issue_cost} : report_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= ST_IDLE;
      cur_cls_ff <= CLS_ALU;
      nreg_ff    <= '0;
      call_ff    <= '0;
      report_ff  <= '0;
    end else begin
      st_ff      <= nxt_st;
      cur_cls_ff <= accept ? issue.cls : cur_cls_ff;
      nreg_ff    <= accept ? issue.n_regs : nreg_ff;
      call_ff    <= accept ? call_cycles : call_ff;
      report_ff  <= nxt_report;
    end
  end

  // Helper: cycles since acceptance, counting the accept cycle as one
  logic [COST_W-1:0] occ_ff;
  logic [COST_W-1:0] occ_now;
  assign occ_now = accept ? CYC_ONE : occ_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      occ_ff <= '0;
    end else begin
      occ_ff <= COST_W'(occ_now + 1'b1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take(ict_class_e c);
    accept && issue.cls == c;
  endsequence
  sequence s_three;
    !retire ##1 !retire ##1 retire;
  endsequence
  sequence s_four;
    !retire ##1 !retire ##1 !retire ##1 retire;
  endsequence

  a_shift_one: assert property ( // see RULE1
      s_take(CLS_SHIFT) |-> retire)
    else $error("Shift did not retire in one cycle");
  a_alu_one: assert property ( // see RULE2
      s_take(CLS_ALU) |-> retire)
    else $error("ALU operation did not retire in one cycle");
  a_mul_one: assert property ( // see RULE3
      s_take(CLS_MUL) |-> retire ##1 issue_ready)
    else $error("Multiply did not retire in one cycle");
  a_ldst_two: assert property ( // see RULE4
      s_take(CLS_LDST) |-> !retire ##1 (retire || abort))
    else $error("Load or store did not take two cycles");
  a_multi_len: assert property ( // see RULE5
      retire && in_exec && cur_cls_ff == CLS_MULTI
      |-> occ_now == COST_W'(CYC_MULTI_BASE + nreg_ff))
    else $error("Multiple transfer length wrong");
  a_popret_len: assert property ( // see RULE6
      retire && !in_idle && cur_cls_ff == CLS_POP_RET
      |-> occ_now == COST_W'(CYC_POPRET_BASE + nreg_ff))
    else $error("Pop with return length wrong");
  a_bcond_taken: assert property ( // see RULE7
      accept && issue.cls == CLS_BCOND && issue.cond_pass |-> s_three)
    else $error("Taken branch did not take three cycles");
  a_bcond_not: assert property ( // see RULE7
      accept && issue.cls == CLS_BCOND && !issue.cond_pass |-> retire)
    else $error("Untaken branch did not take one cycle");
  a_branch_three: assert property ( // see RULE8
      s_take(CLS_BRANCH) |-> s_three)
    else $error("Branch did not take three cycles");
  a_branch_link: assert property ( // see RULE8
      s_take(CLS_BRANCH_LINK) |-> s_four)
    else $error("Branch with link did not take four cycles");
  a_extend_one: assert property ( // see RULE9
      s_take(CLS_EXTEND) |-> retire)
    else $error("Extend did not retire in one cycle");
  a_reverse_one: assert property ( // see RULE10
      s_take(CLS_REVERSE) |-> retire)
    else $error("Reverse did not retire in one cycle");
  a_hint_charge: assert property ( // see RULE11
      s_take(CLS_HINT_WAIT)
      |-> !retire ##1 (retire or (!retire ##1 waiting)))
    else $error("Wait hint charge is not two cycles");
  a_wait_hold: assert property ( // see RULE11
      waiting && !wake |-> !retire ##1 waiting)
    else $error("Wait hint left without wake");
  a_call_cost: assert property ( // see RULE12
      retire && !in_idle && cur_cls_ff == CLS_SUP_CALL
      |-> occ_now == call_ff)
    else $error("Supervisor call length differs from configuration");
  a_pc_write: assert property ( // see RULE13
      s_take(CLS_PC_WRITE) |-> s_three)
    else $error("PC write did not take three cycles");
  a_barrier_four: assert property ( // see RULE13
      s_take(CLS_BARRIER) |-> s_four)
    else $error("Barrier did not take four cycles");
  a_spec_four: assert property ( // see RULE13
      s_take(CLS_SPEC_READ) |-> s_four)
    else $error("Special read did not take four cycles");
  a_hint_one: assert property ( // see RULE14
      s_take(CLS_HINT_ONE) |-> retire)
    else $error("One-cycle hint did not retire at once");

endmodule

// *** test/ict_mem_model.sv ***
// Far-side memory and event source timing model for the cycle timer
`timescale 1ns/1ps
module ict_mem_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       accept,
  input  wire logic [7:0] flt_at,
  input  wire logic [7:0] wake_dly,
  output logic            mem_fault,
  output logic            wake
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  // Saturate so an idle bus never lands on a commanded fault slot other than 8'hff
  assign nxt_cnt = accept ? 8'h01 :
                   ((cnt_ff == 8'hff) ? cnt_ff : cnt_ff + 8'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'hff;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // Zero means a clean transfer; a fault below 8'hff shows in one data cycle only
  assign mem_fault = (flt_at != 8'h00) && (cnt_ff == flt_at);
  assign wake = (cnt_ff >= wake_dly);
endmodule

// *** test/tb_ict_cycle_timer.sv ***
// Self-checking bench for the instruction cycle timer
`timescale 1ns/1ps
module tb_ict_cycle_timer;
  import ict_pkg::*;
  typedef struct packed {
    logic        ab;
    logic [7:0]  lat;
    ict_report_s rep;
  } ict_note_s;
  logic        clk, rst_n, issue_valid, issue_ready, wake, mem_fault;
  logic        retire, abort, waiting, rep_due, rdy_due;
  logic [7:0]  call_cycles, wake_dly, flt_at;
  logic [9:0]  got;
  ict_issue_s  issue;
  ict_report_s report;
  ict_note_s   notes[$];
  ict_note_s   cur, ex;
  int          n_mismatch, cmp_count, cyc, acc, seed, r;

  ict_cycle_timer DUT (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue(issue), .call_cycles(call_cycles),
    .wake(wake), .mem_fault(mem_fault), .retire(retire), .abort(abort),
    .waiting(waiting), .report(report));
  ict_mem_model mem (.clk(clk), .rst_n(rst_n),
    .accept(issue_valid && issue_ready), .flt_at(flt_at),
    .wake_dly(wake_dly), .mem_fault(mem_fault), .wake(wake));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_cost(ict_class_e c, logic [4:0] n,
                                          logic cp, logic [7:0] s);
    case (c)
      CLS_LDST:     return 8'h02;
      CLS_MULTI:    return 8'h01 + {3'h0, n};
      CLS_POP_RET:  return 8'h04 + {3'h0, n};
      CLS_BCOND:    return cp ? 8'h03 : 8'h01;
      CLS_BRANCH, CLS_PC_WRITE: return 8'h03;
      CLS_BRANCH_LINK, CLS_BARRIER, CLS_SPEC_READ: return 8'h04;
      CLS_HINT_WAIT: return 8'h02;
      CLS_SUP_CALL: return (s == 8'h00) ? 8'h01 : s;
      default:      return 8'h01;
    endcase
  endfunction

  // Far-side timing must not change before the previous instruction ends
  task automatic issue_op(input ict_class_e c, input logic [4:0] n,
                          input logic cp, input logic [7:0] s,
                          input logic [7:0] wd, input logic [7:0] fa);
    ict_note_s nt;
    int k;
    k = 0;
    while (issue_ready !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    nt.rep.cls = c;
    nt.rep.cost = exp_cost(c, n, cp, s);
    nt.ab = (fa != 8'h00);
    nt.lat = nt.ab ? fa + 8'h01 :
             ((c == CLS_HINT_WAIT) ? wd + 8'h01 : nt.rep.cost);
    notes.push_back(nt);
    issue_valid = 1'b1;
    issue = '{c, n, cp};
    call_cycles = s;
    wake_dly = wd;
    flt_at = fa;
    @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    // Every retire or abort must hand the port back on the next cycle
    if (rdy_due) begin
      chk(32'(issue_ready), 32'h0000_0001);
    end
    rdy_due = (retire === 1'b1 || abort === 1'b1);
    if (rep_due) begin
      chk(32'(report), 32'(cur.rep));
    end
    rep_due = 1'b0;
    if (issue_valid && issue_ready && notes.size() > 0) begin
      acc = cyc;
      cur = notes[0];
      rep_due = 1'b1;
    end
    if (waiting === 1'b1 && cur.rep.cls !== CLS_HINT_WAIT) begin
      chk(32'(waiting), 32'h0000_0000);
    end
    if (retire === 1'b1 || abort === 1'b1) begin
      if (notes.size() == 0) begin
        chk(32'(retire), 32'h0000_0000);
      end else begin
        ex = notes.pop_front();
        got = {retire, abort, 8'(cyc - acc + 1)};
        chk(32'(got), 32'({~ex.ab, ex.ab, ex.lat}));
      end
    end
    cyc++;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    seed = 32'hfb02_f72d;
    rst_n = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    call_cycles = 8'h00;
    wake_dly = 8'hff;
    flt_at = 8'h00;
    rep_due = 1'b0;
    rdy_due = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 17; i++) begin
      issue_op(ict_class_e'(5'(i)), 5'h03, i[0], 8'h05, 8'h01,
               8'h00);
    end
    issue_op(CLS_BCOND, 5'h00, 1'b1, 8'h00, 8'h01, 8'h00);
    issue_op(CLS_SUP_CALL, 5'h00, 1'b0, 8'h00, 8'h01, 8'h00);
    $display("test all classes done");
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      issue_op(ict_class_e'(5'({r[7:0]} % 17)), {2'h0, r[10:8]}, r[11],
               {4'h0, r[15:12]}, 8'h01 + {5'h0, r[18:16]}, 8'h00);
    end
    $display("test random stream done");
    issue_op(CLS_LDST, 5'h00, 1'b0, 8'h00, 8'hff, 8'h01);
    issue_op(CLS_MULTI, 5'h03, 1'b0, 8'h00, 8'hff, 8'h02);
    issue_op(CLS_POP_RET, 5'h02, 1'b0, 8'h00, 8'hff, 8'h03);
    issue_op(CLS_POP_RET, 5'h02, 1'b0, 8'h00, 8'hff, 8'h00);
    issue_op(CLS_HINT_WAIT, 5'h00, 1'b0, 8'h00, 8'h0c, 8'h00);
    $display("test faults and long wait done");
    issue_valid = 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(notes.size()), 32'h0000_0000);
    summarize();
  end
endmodule
